// file: hdl/bsi_pkg.sv
package bsi_pkg;
    localparam logic [31:0] MAGIC_WORD = 32'h41504954;
    localparam logic [31:0] OP_LOAD    = 32'h58535901;
    localparam logic [31:0] OP_JUMP    = 32'h58535905;
    localparam logic [31:0] OP_CLOSE   = 32'h58535906;
    localparam logic [31:0] OP_SET     = 32'h58535907;
    localparam logic [31:0] OP_FILL    = 32'h5853590A;
    localparam logic [31:0] OP_GET     = 32'h5853590D;
    localparam logic [7:0]  TY_BYTE    = 8'h00;
    localparam logic [7:0]  TY_HALF    = 8'h01;
    localparam logic [7:0]  TY_WORD    = 8'h02;
    localparam logic [7:0]  TY_FIELD   = 8'h03;
    localparam logic [7:0]  TY_BITS    = 8'h04;
    localparam logic [7:0]  PAT_W8     = 8'h08;
    localparam logic [7:0]  PAT_W16    = 8'h10;
    localparam logic [7:0]  MULT_QUICK = 8'h0C;
    localparam logic [7:0]  MULT_RESET = 8'h01;
    localparam logic [2:0]  N_LOAD     = 3'h2;
    localparam logic [2:0]  N_FILL     = 3'h4;
    localparam logic [2:0]  N_SET      = 3'h4;
    localparam logic [2:0]  N_GET      = 3'h3;
    localparam logic [2:0]  N_JUMP     = 3'h1;
    localparam int          FIFO_DEPTH = 16;
    localparam int          WORD_W     = 32;

    typedef enum logic [12:0] {
        S_HDR  = 13'h0001, S_OPC  = 13'h0002, S_ARG  = 13'h0004,
        S_EXEC = 13'h0008, S_MRD  = 13'h0010, S_MWR  = 13'h0020,
        S_DLY  = 13'h0040, S_LOAD = 13'h0080, S_FILL = 13'h0100,
        S_JMP  = 13'h0200, S_TAIL = 13'h0400, S_DONE = 13'h0800,
        S_ERR  = 13'h1000
    } bsi_state_t;

    // Mask of bits start..stop inclusive
    function automatic logic [31:0] field_mask(input logic [31:0] ty);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 32; i++) begin
            m[i] = (i >= int'(ty[12:8])) && (i <= int'(ty[20:16]));
        end
        return m;
    endfunction

    // Byte enables of the last word of a run
    function automatic logic [3:0] tail_be(input logic [1:0] rem);
        logic [3:0] be;
        be = 4'hF;
        if (rem == 2'h1) be = 4'h1;
        if (rem == 2'h2) be = 4'h3;
        if (rem == 2'h3) be = 4'h7;
        return be;
    endfunction
endpackage

// file: hdl/bsi_top.sv
// Behaviour
// - Check header magic before any command
// - Consume script as whole 32-bit words
// - Opcode decode sets operand count, action
// - Final branch stops, hands over to application
// - Write command takes four operand words
// - Wait delay-operand clocks after each write command
// - Type low byte selects access kind
// - Type holds stop, start, kind fields
// - Start/stop ignored for byte, half, word
// - Field kind: read, merge range, write back
// - Bits kind: read first, then write
// - Read command: same operands, no delay
// - Read result right-justified, zero-filled
// - Section load copies contents to memory
// - Pattern fill repeats 8/16/32-bit pattern
// - Jump hands target address to loader
// - Resume script after secondary loader ends
// - Quick boot selects fixed clock multiplier
// - Bypass modes skip script parsing
// - Final branch: entry, then two more words
`timescale 1ns/100ps
module bsi_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          rdy_q, rdy_d, push, pop;

    assign in_ready  = rdy_q;
    assign out_valid = cnt_q != '0;
    assign out_data  = mem[rp_q];
    assign push      = in_valid && rdy_q;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = (AW+1)'(cnt_q + push - pop);
        rdy_d = cnt_d < (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem[wp_q] <= in_data;
    end
endmodule

module bsi_top
    import bsi_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        s_valid,
    input  wire logic [31:0] s_data,
    output logic             s_ready,
    input  wire logic        bypass_mode,
    input  wire logic        quick_clock_boot,
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [3:0]       mem_be,
    output logic [31:0]      mem_wdata,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic             rd_valid,
    output logic [31:0]      rd_data,
    output logic             jump_req,
    output logic [31:0]      jump_addr,
    input  wire logic        loader_done,
    output logic             boot_done,
    output logic [31:0]      entry_addr,
    output logic             script_err,
    output logic [7:0]       clk_mult
);
    bsi_state_t  state_q, state_d;
    logic [31:0] op_q, op_d, addr_q, addr_d, left_q, left_d, dly_q, dly_d;
    logic [31:0] arg_q [4];
    logic [31:0] arg_d [4];
    logic [1:0]  idx_q, idx_d;
    logic [2:0]  need_q, need_d;
    logic        tail_q, tail_d, req_q, req_d, we_q, we_d;
    logic [3:0]  be_q, be_d;
    logic [31:0] wd_q, wd_d, rdd_q, rdd_d, ja_q, ja_d, ent_q, ent_d;
    logic        rdv_q, rdv_d, jr_q, jr_d, done_q, done_d, err_q, err_d;
    logic [7:0]  mult_q, mult_d, ty;
    logic [31:0] f_data, msk, shr, pat;
    logic        f_valid, f_ready;

    bsi_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (s_valid),
        .in_data   (s_data),
        .in_ready  (s_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready)
    );

    assign ty = arg_q[2][7:0];
    assign msk = field_mask(arg_q[2]);
    assign shr = mem_rdata >> {arg_q[0][1:0], 3'b000};
    assign pat = (arg_q[2][7:0] == PAT_W8)  ? {4{arg_q[3][7:0]}} :
                 (arg_q[2][7:0] == PAT_W16) ? {2{arg_q[3][15:0]}} :
                 arg_q[3];

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        arg_d = arg_q;
        idx_d = idx_q;
        need_d = need_q;
        addr_d = addr_q;
        left_d = left_q;
        dly_d = dly_q;
        tail_d = tail_q;
        req_d = req_q;
        we_d = we_q;
        be_d = be_q;
        wd_d = wd_q;
        rdv_d = 1'b0;
        rdd_d = rdd_q;
        jr_d = jr_q;
        ja_d = ja_q;
        done_d = done_q;
        ent_d = ent_q;
        err_d = err_q;
        f_ready = 1'b0;
        mult_d = quick_clock_boot ? MULT_QUICK : MULT_RESET;
        unique case (state_q)
            S_HDR: begin
                f_ready = 1'b1;
                if (f_valid && !bypass_mode) begin
                    if (f_data == MAGIC_WORD) begin
                        state_d = S_OPC;
                    end else begin
                        state_d = S_ERR;
                        err_d = 1'b1;
                    end
                end
            end
            S_OPC: begin
                f_ready = 1'b1;
                if (f_valid) begin
                    op_d = f_data;
                    idx_d = 2'h0;
                    state_d = S_ARG;
                    if (f_data == OP_LOAD) need_d = N_LOAD;
                    else if (f_data == OP_FILL) need_d = N_FILL;
                    else if (f_data == OP_SET) need_d = N_SET;
                    else if (f_data == OP_GET) need_d = N_GET;
                    else if (f_data == OP_JUMP || f_data == OP_CLOSE) begin
                        need_d = N_JUMP;
                    end else begin
                        state_d = S_ERR;
                        err_d = 1'b1;
                    end
                end
            end
            S_ARG: begin
                f_ready = 1'b1;
                if (f_valid) begin
                    arg_d[idx_q] = f_data;
                    idx_d = 2'(idx_q + 2'h1);
                    if ({1'b0, idx_q} == 3'(need_q - 3'h1)) state_d = S_EXEC;
                end
            end
            S_EXEC: begin
                addr_d = {arg_q[0][31:2], 2'b00};
                left_d = {2'b00, arg_q[1][31:2]} + 32'(|arg_q[1][1:0]);
                if (op_q == OP_SET || op_q == OP_GET) begin
                    req_d = 1'b1;
                    be_d = 4'hF;
                    wd_d = arg_q[1];
                    if (op_q == OP_GET || ty == TY_FIELD || ty == TY_BITS) begin
                        we_d = 1'b0;
                        state_d = S_MRD;
                    end else begin
                        we_d = 1'b1;
                        state_d = S_MWR;
                        if (ty == TY_BYTE) begin
                            be_d = 4'h1 << arg_q[0][1:0];
                            wd_d = {4{arg_q[1][7:0]}};
                        end else if (ty == TY_HALF) begin
                            be_d = 4'h3 << {arg_q[0][1], 1'b0};
                            wd_d = {2{arg_q[1][15:0]}};
                        end
                    end
                end else if (op_q == OP_LOAD || op_q == OP_FILL) begin
                    if (left_d == '0) state_d = S_OPC;
                    else if (op_q == OP_LOAD) state_d = S_LOAD;
                    else state_d = S_FILL;
                end else if (op_q == OP_JUMP) begin
                    ja_d = arg_q[0];
                    jr_d = 1'b1;
                    state_d = S_JMP;
                end else begin
                    ent_d = arg_q[0];
                    tail_d = 1'b0;
                    state_d = S_TAIL;
                end
            end
            S_MRD: begin
                if (mem_ack) begin
                    if (op_q == OP_GET) begin
                        req_d = 1'b0;
                        rdv_d = 1'b1;
                        state_d = S_OPC;
                        if (ty == TY_BYTE) rdd_d = {24'h000000, shr[7:0]};
                        else if (ty == TY_HALF) rdd_d = {16'h0000, shr[15:0]};
                        else if (ty == TY_WORD) rdd_d = mem_rdata;
                        else rdd_d = (mem_rdata & msk) >> arg_q[2][12:8];
                    end else begin
                        we_d = 1'b1;
                        state_d = S_MWR;
                        if (ty == TY_FIELD) begin
                            wd_d = (mem_rdata & ~msk)
                                 | ((arg_q[1] << arg_q[2][12:8]) & msk);
                        end
                    end
                end
            end
            S_MWR: begin
                if (mem_ack) begin
                    req_d = 1'b0;
                    state_d = S_OPC;
                    if (op_q == OP_SET) begin
                        dly_d = arg_q[3];
                        if (arg_q[3] != '0) state_d = S_DLY;
                    end else if (op_q != OP_GET) begin
                        addr_d = addr_q + 32'h4;
                        left_d = left_q - 32'h1;
                        if (left_q != 32'h1) begin
                            state_d = (op_q == OP_LOAD) ? S_LOAD : S_FILL;
                        end
                    end
                end
            end
            S_DLY: begin
                dly_d = dly_q - 32'h1;
                if (dly_q == 32'h1) state_d = S_OPC;
            end
            S_LOAD, S_FILL: begin
                f_ready = (state_q == S_LOAD);
                if (f_valid || state_q == S_FILL) begin
                    wd_d = (state_q == S_LOAD) ? f_data : pat;
                    be_d = (left_q == 32'h1) ? tail_be(arg_q[1][1:0]) : 4'hF;
                    req_d = 1'b1;
                    we_d = 1'b1;
                    state_d = S_MWR;
                end
            end
            S_JMP: begin
                if (loader_done) begin
                    jr_d = 1'b0;
                    state_d = S_OPC;
                end
            end
            S_TAIL: begin
                f_ready = 1'b1;
                if (f_valid) begin
                    tail_d = 1'b1;
                    if (tail_q) begin
                        done_d = 1'b1;
                        state_d = S_DONE;
                    end
                end
            end
            S_DONE, S_ERR: begin
            end
            default: begin
                state_d = S_ERR;
                err_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= S_HDR;
            op_q <= '0;
            arg_q <= '{default: '0};
            idx_q <= '0;
            need_q <= '0;
            addr_q <= '0;
            left_q <= '0;
            dly_q <= '0;
            tail_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            be_q <= '0;
            wd_q <= '0;
            rdv_q <= 1'b0;
            rdd_q <= '0;
            jr_q <= 1'b0;
            ja_q <= '0;
            done_q <= 1'b0;
            ent_q <= '0;
            err_q <= 1'b0;
            mult_q <= MULT_RESET;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            arg_q <= arg_d;
            idx_q <= idx_d;
            need_q <= need_d;
            addr_q <= addr_d;
            left_q <= left_d;
            dly_q <= dly_d;
            tail_q <= tail_d;
            req_q <= req_d;
            we_q <= we_d;
            be_q <= be_d;
            wd_q <= wd_d;
            rdv_q <= rdv_d;
            rdd_q <= rdd_d;
            jr_q <= jr_d;
            ja_q <= ja_d;
            done_q <= done_d;
            ent_q <= ent_d;
            err_q <= err_d;
            mult_q <= mult_d;
        end
    end

    assign mem_req = req_q;
    assign mem_we = we_q;
    assign mem_addr = addr_q;
    assign mem_be = be_q;
    assign mem_wdata = wd_q;
    assign rd_valid = rdv_q;
    assign rd_data = rdd_q;
    assign jump_req = jr_q;
    assign jump_addr = ja_q;
    assign boot_done = done_q;
    assign entry_addr = ent_q;
    assign script_err = err_q;
    assign clk_mult = mult_q;

    a_magic_check: assert property (@(posedge clk) disable iff (!nrst)
        state_q == S_HDR && f_valid && !bypass_mode && f_data != MAGIC_WORD
        |=> script_err && state_q == S_ERR)
        else $error("bad magic not flagged");
    a_err_halt: assert property (@(posedge clk) disable iff (!nrst)
        script_err |=> script_err && !f_ready && !mem_req)
        else $error("activity after abort");
    a_get_zero: assert property (@(posedge clk) disable iff (!nrst)
        rd_valid && ty == TY_BYTE |-> rd_data[31:8] == 24'h000000)
        else $error("byte read not zero-filled");
    a_delay_len: assert property (@(posedge clk) disable iff (!nrst)
        state_q == S_MWR && mem_ack && op_q == OP_SET && arg_q[3] == 32'h3
        |=> (state_q == S_DLY) [*3] ##1 state_q == S_OPC)
        else $error("write delay length wrong");
    a_close_done: assert property (@(posedge clk) disable iff (!nrst)
        state_q == S_TAIL && f_valid && tail_q
        |=> boot_done ##1 boot_done && !f_ready)
        else $error("final branch did not end boot");
    a_jump_resume: assert property (@(posedge clk) disable iff (!nrst)
        jump_req && loader_done |=> !jump_req && state_q == S_OPC)
        else $error("no resume after loader");
    a_jump_hold: assert property (@(posedge clk) disable iff (!nrst)
        jump_req && !loader_done |=> jump_req && $stable(jump_addr))
        else $error("jump request dropped early");
    a_quick_mult: assert property (@(posedge clk) disable iff (!nrst)
        quick_clock_boot |=> clk_mult == MULT_QUICK)
        else $error("quick boot multiplier wrong");
    a_byte_lane: assert property (@(posedge clk) disable iff (!nrst)
        mem_req && mem_we && op_q == OP_SET && ty == TY_BYTE
        |-> $onehot(mem_be))
        else $error("byte write enables wrong");
endmodule

// file: bench/bsi_mem_model.sv
`timescale 1ns/100ps
// Word memory and secondary loader on the far side of the interpreter
module bsi_mem_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  lat,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [3:0]  mem_be,
    input  wire logic [31:0] mem_wdata,
    output logic [31:0]      mem_rdata,
    output logic             mem_ack,
    input  wire logic        jump_req,
    output logic             loader_done
);
    logic [31:0] mem [16];
    logic [3:0]  cnt;
    logic [3:0]  lcnt;
    logic [3:0]  idx;

    assign idx = mem_addr[5:2];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 16; i++) begin
                mem[i] <= {16'hA5A5, 12'h000, 4'(i)};
            end
            mem_ack   <= 1'b0;
            cnt       <= 4'h0;
            mem_rdata <= 32'h5A5AF00F;
        end else begin
            mem_ack   <= 1'b0;
            // Read data is only meaningful with the acknowledge
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (cnt >= lat) begin
                    mem_ack   <= 1'b1;
                    cnt       <= 4'h0;
                    mem_rdata <= mem[idx];
                    for (int b = 0; b < 4; b++) begin
                        if (mem_we && mem_be[b]) begin
                            mem[idx][8*b +: 8] <= mem_wdata[8*b +: 8];
                        end
                    end
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end

    // Secondary loader finishes a few cycles after being started
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lcnt        <= 4'h0;
            loader_done <= 1'b0;
        end else begin
            lcnt        <= jump_req ? lcnt + 4'h1 : 4'h0;
            loader_done <= jump_req && (lcnt == 4'h3);
        end
    end
endmodule

// file: bench/bsi_top_bench.sv
`timescale 1ns/100ps
module bsi_top_bench;
    import bsi_pkg::*;
    logic        clk;
    logic        nrst;
    logic        s_valid;
    logic [31:0] s_data;
    logic        s_ready;
    logic        bypass_mode;
    logic        quick_clock_boot;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [3:0]  mem_be;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic        mem_ack;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic        jump_req;
    logic [31:0] jump_addr;
    logic        loader_done;
    logic        boot_done;
    logic [31:0] entry_addr;
    logic        script_err;
    logic [7:0]  clk_mult;
    logic [3:0]  lat;
    logic [31:0] jaddr;
    logic [31:0] scr [$];
    logic [31:0] rdq [$];
    logic        weq [$];
    int          ackq [$];
    int          num_errors;
    int          checks_done;
    int          cyc;
    int          jumps;
    logic [3:0]  mi [9] = '{3, 4, 5, 8, 9, 0, 1, 14, 15};
    logic [31:0] mv [9] = '{32'hCAFEF00D, 32'hA5A5AB04, 32'hBEEF0005,
                            32'hA5A503C8, 32'h12345678, 32'h11223344,
                            32'hA5A57788, 32'h5A5A5A5A, 32'h5A5A5A5A};

    bsi_top dut_u (.clk(clk), .nrst(nrst), .s_valid(s_valid),
        .s_data(s_data), .s_ready(s_ready), .bypass_mode(bypass_mode),
        .quick_clock_boot(quick_clock_boot), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .rd_valid(rd_valid), .rd_data(rd_data), .jump_req(jump_req),
        .jump_addr(jump_addr), .loader_done(loader_done),
        .boot_done(boot_done), .entry_addr(entry_addr),
        .script_err(script_err), .clk_mult(clk_mult));

    bsi_mem_model mem_u (.clk(clk), .nrst(nrst), .lat(lat),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .jump_req(jump_req), .loader_done(loader_done));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Record memory answers, read results and the jump target
    always @(posedge clk) begin
        cyc++;
        if (mem_ack === 1'b1) begin
            ackq.push_back(cyc);
            weq.push_back(mem_we);
        end
        if (rd_valid === 1'b1) rdq.push_back(rd_data);
        if (jump_req === 1'b1 && jumps == 0) begin
            jaddr = jump_addr;
            jumps++;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic bound(input int n);
        if (n >= 3000) begin
            num_errors++;
            $display("Error at %0t: wait timed out", $time);
            test_done;
        end
    endtask

    task automatic do_reset;
        nrst    <= 1'b0;
        s_valid <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        ackq.delete();
        weq.delete();
        rdq.delete();
        jumps = 0;
        repeat (2) @(posedge clk);
    endtask

    // Whole 32-bit words, each held until taken
    task automatic send_all;
        int n;
        for (int i = 0; i < scr.size(); i++) begin
            s_valid <= 1'b1;
            s_data  <= scr[i];
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (s_ready !== 1'b1 && n < 3000);
            bound(n);
        end
        s_valid <= 1'b0;
    endtask

    task automatic t_errors;
        int n;
        for (int k = 0; k < 3; k++) begin
            do_reset;
            if (k == 0) scr = '{32'h41504955, OP_SET};
            else if (k == 1) scr = '{MAGIC_WORD, 32'h58535909, OP_SET};
            else scr = '{MAGIC_WORD, 32'h58535903, OP_GET};
            send_all;
            n = 0;
            while (script_err !== 1'b1 && n < 3000) begin
                @(posedge clk);
                n++;
            end
            bound(n);
            repeat (4) @(posedge clk);
            chk(script_err, 1);
            chk(ackq.size(), 0);
        end
        $display("error test done");
    endtask

    task automatic t_bypass;
        bypass_mode <= 1'b1;
        do_reset;
        scr = '{32'h12345678, OP_SET, 32'h0, 32'h0, 32'h2, 32'h0};
        send_all;
        repeat (20) @(posedge clk);
        chk(script_err, 0);
        chk(ackq.size(), 0);
        chk(s_ready, 1);
        bypass_mode <= 1'b0;
        $display("bypass test done");
    endtask

    task automatic t_script(input logic [3:0] l, input logic q);
        int n;
        lat              <= l;
        quick_clock_boot <= q;
        do_reset;
        // Writes first, loads after them
        scr = '{MAGIC_WORD,
            OP_SET, 32'h0C, 32'hCAFEF00D, 32'h2, 32'h7,
            OP_SET, 32'h11, 32'hAB, 32'h00070300, 32'h0,
            OP_SET, 32'h16, 32'hBEEF, 32'h1, 32'h0,
            OP_SET, 32'h20, 32'h3C, 32'h000B0403, 32'h0,
            OP_SET, 32'h24, 32'h12345678, 32'h00070004, 32'h0,
            OP_GET, 32'h2A, 32'h0, 32'h0, OP_GET, 32'h2E, 32'h0, 32'h1,
            OP_GET, 32'h30, 32'h0, 32'h2, OP_GET, 32'h34, 32'h0, 32'h00171003,
            OP_LOAD, 32'h0, 32'h6, 32'h11223344, 32'h55667788,
            OP_JUMP, 32'h1000,
            OP_FILL, 32'h38, 32'h8, 32'h8, 32'h5A,
            OP_CLOSE, 32'h2000, 32'h2, 32'hE};
        fork
            send_all;
            begin
                n = 0;
                while (boot_done !== 1'b1 && n < 3000) begin
                    @(posedge clk);
                    n++;
                end
            end
        join
        bound(n);
        chk(clk_mult, q ? MULT_QUICK : MULT_RESET);
        chk(entry_addr, 32'h2000);
        chk(ackq.size(), 15);
        chk((ackq[1] - ackq[0]) - (ackq[2] - ackq[1]), 7);
        chk({weq[3], weq[4], weq[5], weq[6]}, 4'h5);
        chk(rdq.size(), 4);
        chk(rdq[0], 32'hA5);
        chk(rdq[1], 32'hA5A5);
        chk(rdq[2], 32'hA5A5000C);
        chk(rdq[3], 32'hA5);
        chk(jaddr, 32'h1000);
        for (int k = 0; k < 9; k++) begin
            chk(mem_u.mem[mi[k]], mv[k]);
        end
        $display("script test done, latency %0d", l);
    endtask

    initial begin
        nrst             = 1'b0;
        s_valid          = 1'b0;
        s_data           = 32'h0;
        bypass_mode      = 1'b0;
        quick_clock_boot = 1'b0;
        lat              = 4'h0;
        num_errors       = 0;
        checks_done      = 0;
        cyc              = 0;
        jumps            = 0;
        t_errors;
        t_bypass;
        t_script(4'h0, 1'b1);
        t_script(4'h3, 1'b0);
        test_done;
    end
endmodule
